// >>> core/xy_pkg.sv
package xy_pkg;
   localparam int WORD_W    = 16;
   localparam int WORDS     = 16;
   localparam int ADDR_W    = 7;
   // Byte addresses: word i at 4*i, control word after the matrix
   localparam logic [ADDR_W-1:0] MATRIX_BASE  = 7'h00;
   localparam logic [ADDR_W-1:0] CONTROL_ADDR = 7'h40;
   localparam int ADDR_LSB  = 2;
   localparam int CTL_READ_BIT  = 0;
   localparam int CTL_WRITE_BIT = 1;
   localparam logic [3:0] HALF_LANES = 4'h3;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

   typedef logic [WORD_W-1:0] word_t;
   typedef word_t [WORDS-1:0] matrix_t;

   typedef struct packed {
      logic               read;
      logic               write;
      logic [ADDR_W-1:0]  address;
      logic [3:0]         byteenable;
      logic [31:0]        writedata;
   } bus_req_t;

   typedef struct packed {
      logic        read_select;
      logic        reverse_select;
   } control_t;
endpackage

// >>> core/bit_reverser.sv
`timescale 1ns/1ns
`default_nettype none
module bit_reverser
   import xy_pkg::*;
(
   // Data
   input  wire word_t  din,
   input  wire logic   enable,
   output word_t       dout
);
   always_comb begin
      dout = din;
      if (enable) begin
         for (int n = 0; n < WORD_W; n++) begin
            dout[WORD_W-1-n] = din[n];
         end
      end
   end
endmodule
`default_nettype wire

// >>> core/matrix_reader.sv
`timescale 1ns/1ns
`default_nettype none
module matrix_reader
   import xy_pkg::*;
(
   // Matrix and selection
   input  wire matrix_t  matrix,
   input  wire logic [3:0] index,
   input  wire logic     read_select,
   output word_t         dout
);
   always_comb begin
      dout = matrix[index];
      if (!read_select) begin
         for (int k = 0; k < WORDS; k++) begin
            dout[k] = matrix[k][index];
         end
      end
   end
endmodule
`default_nettype wire

// >>> core/bit_matrix_transpose_unit.sv
`timescale 1ns/1ns
`default_nettype none
module bit_matrix_transpose_unit
   import xy_pkg::*;
(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Avalon-MM slave
   input  wire logic [ADDR_W-1:0] avs_address,
   input  wire logic         avs_read,
   input  wire logic         avs_write,
   input  wire logic [3:0]   avs_byteenable,
   input  wire logic [31:0]  avs_writedata,
   output logic [31:0]       avs_readdata,
   output logic              avs_waitrequest
);
   typedef struct packed {
      matrix_t     matrix;
      control_t    control;
      logic        done;
      logic        waitrequest;
      logic [31:0] readdata;
   } state_t;

   state_t state_reg;
   state_t state_next;
   bus_req_t req;
   word_t stored_word;
   word_t read_word;
   logic [3:0] index;
   logic in_matrix;

   function automatic logic [3:0] word_index(input logic [ADDR_W-1:0] a);
      return a[ADDR_LSB +: 4];
   endfunction

   assign req = '{read: avs_read, write: avs_write, address: avs_address,
                  byteenable: avs_byteenable, writedata: avs_writedata};
   assign index = word_index(req.address);
   assign in_matrix = (req.address < CONTROL_ADDR) && (req.address[ADDR_LSB-1:0] == 2'b00);

   bit_reverser u_rev (
      .din    (req.writedata[WORD_W-1:0]),
      .enable (state_reg.control.reverse_select),
      .dout   (stored_word)
   );

   matrix_reader u_read (
      .matrix      (state_reg.matrix),
      .index       (index),
      .read_select (state_reg.control.read_select),
      .dout        (read_word)
   );

   // One wait cycle, then the access completes; done keeps it from repeating
   always_comb begin
      state_next = state_reg;
      state_next.done = 1'b0;
      if ((req.read || req.write) && !state_reg.done) begin
         state_next.done = 1'b1;
         if (req.write && in_matrix) begin
            // Byte-wide writes still store the whole half word, as software must avoid them
            state_next.matrix[index] = stored_word;
         end else if (req.write && req.address == CONTROL_ADDR && req.byteenable[0]) begin
            state_next.control.read_select    = req.writedata[CTL_READ_BIT];
            state_next.control.reverse_select = req.writedata[CTL_WRITE_BIT];
         end
         if (req.read && in_matrix) begin
            state_next.readdata = {16'h0000, read_word};
         end else if (req.read && req.address == CONTROL_ADDR) begin
            state_next.readdata = {30'h0000_0000, state_reg.control.reverse_select,
                                   state_reg.control.read_select};
         end else if (req.read) begin
            state_next.readdata = UNMAPPED_DATA;
         end
      end
      // Registered so the bus sees waitrequest straight from a flop
      state_next.waitrequest = !state_next.done;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg.matrix   <= '0;
         state_reg.control  <= '0;
         state_reg.done     <= 1'b0;
         state_reg.readdata <= '0;
         state_reg.waitrequest <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   assign avs_readdata = state_reg.readdata;
   assign avs_waitrequest = state_reg.waitrequest;

   // Reference models for the checks, written apart from the datapath modules
   function automatic word_t ref_column(input matrix_t m, input logic [3:0] j);
      word_t c;
      c = '0;
      for (int k = 0; k < WORDS; k++) begin
         c[k] = m[k][j];
      end
      return c;
   endfunction

   function automatic word_t ref_reverse(input word_t w);
      word_t r;
      r = '0;
      for (int n = 0; n < WORD_W; n++) begin
         r[WORD_W-1-n] = w[n];
      end
      return r;
   endfunction

   // True when every word but the one at skip is the same in both copies
   function automatic logic others_same(input matrix_t a, input matrix_t b, input logic [3:0] skip);
      logic same;
      same = 1'b1;
      for (int k = 0; k < WORDS; k++) begin
         if (k != int'(skip) && a[k] != b[k]) begin
            same = 1'b0;
         end
      end
      return same;
   endfunction

   // Access phase seen at the first edge of a request; results show one edge later
   logic first_edge;
   logic matrix_wr;
   logic matrix_rd;
   logic control_wr;
   logic control_rd;
   logic unmapped_rd;

   assign first_edge  = (req.read || req.write) && !state_reg.done;
   assign matrix_wr   = first_edge && req.write && in_matrix;
   assign matrix_rd   = first_edge && req.read && in_matrix;
   assign control_wr  = first_edge && req.write && (req.address == CONTROL_ADDR);
   assign control_rd  = first_edge && req.read && (req.address == CONTROL_ADDR);
   assign unmapped_rd = first_edge && req.read && !in_matrix && (req.address != CONTROL_ADDR);

   // Reset behaviour
   chk_reset_control: assert property (@(posedge clk)
      $fell(rst)
      |->
      state_reg.control == '0)
      else $error("control not cleared by reset");

   chk_reset_wait: assert property (@(posedge clk)
      rst
      |->
      avs_waitrequest)
      else $error("waitrequest low during reset");

   chk_release_wait: assert property (@(posedge clk)
      $fell(rst)
      |->
      avs_waitrequest)
      else $error("waitrequest low right after reset");

   // Storing input words
   chk_write_stored: assert property (@(posedge clk) disable iff (rst)
      matrix_wr && !state_reg.control.reverse_select
      |=>
      state_reg.matrix[$past(index)] == $past(req.writedata[WORD_W-1:0]))
      else $error("plain write not stored as is");

   chk_write_reversed: assert property (@(posedge clk) disable iff (rst)
      matrix_wr && state_reg.control.reverse_select
      |=>
      state_reg.matrix[$past(index)] == ref_reverse($past(req.writedata[WORD_W-1:0])))
      else $error("reversed write wrong");

   chk_write_others: assert property (@(posedge clk) disable iff (rst)
      matrix_wr
      |=>
      others_same(state_reg.matrix, $past(state_reg.matrix), $past(index)))
      else $error("write touched another word");

   chk_matrix_hold: assert property (@(posedge clk) disable iff (rst)
      !matrix_wr
      |=>
      $stable(state_reg.matrix))
      else $error("matrix changed without write");

   // Reading output words
   chk_read_direct: assert property (@(posedge clk) disable iff (rst)
      matrix_rd && state_reg.control.read_select
      |=>
      avs_readdata[WORD_W-1:0] == $past(state_reg.matrix[index]))
      else $error("direct read wrong");

   chk_read_transpose: assert property (@(posedge clk) disable iff (rst)
      matrix_rd && !state_reg.control.read_select
      |=>
      avs_readdata[WORD_W-1:0] == ref_column($past(state_reg.matrix), $past(index)))
      else $error("transposed read wrong");

   chk_upper_zero: assert property (@(posedge clk) disable iff (rst)
      matrix_rd
      |=>
      avs_readdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");

   chk_unmapped_read: assert property (@(posedge clk) disable iff (rst)
      unmapped_rd
      |=>
      avs_readdata == UNMAPPED_DATA)
      else $error("unmapped read not zero");

   // Read data only moves when a read is taken, so the master may sample it late
   chk_readdata_hold: assert property (@(posedge clk) disable iff (rst)
      !(first_edge && req.read)
      |=>
      $stable(avs_readdata))
      else $error("read data changed without read");

   // Bus handshake
   chk_wait_one: assert property (@(posedge clk) disable iff (rst)
      (req.read || req.write) && avs_waitrequest
      |=>
      !avs_waitrequest)
      else $error("access not answered in one cycle");

   chk_wait_release: assert property (@(posedge clk) disable iff (rst)
      !avs_waitrequest
      |=>
      avs_waitrequest)
      else $error("waitrequest low for more than one cycle");

   // Control bits
   chk_ctl_hold: assert property (@(posedge clk) disable iff (rst)
      !(req.write && req.address == CONTROL_ADDR)
      |=>
      $stable(state_reg.control))
      else $error("control changed without write");

   chk_ctl_write: assert property (@(posedge clk) disable iff (rst)
      control_wr && req.byteenable[0]
      |=>
      state_reg.control.read_select == $past(req.writedata[CTL_READ_BIT]) &&
      state_reg.control.reverse_select == $past(req.writedata[CTL_WRITE_BIT]))
      else $error("control write not taken");

   // A control write without lane 0 is dropped rather than half applied
   chk_ctl_lane: assert property (@(posedge clk) disable iff (rst)
      control_wr && !req.byteenable[0]
      |=>
      $stable(state_reg.control))
      else $error("control changed by write without lane 0");

   chk_ctl_readback: assert property (@(posedge clk) disable iff (rst)
      control_rd
      |=>
      avs_readdata == {30'h0000_0000, $past(state_reg.control.reverse_select),
                       $past(state_reg.control.read_select)})
      else $error("control readback wrong");

   // Main scenarios
   cov_transpose: cover property (@(posedge clk) disable iff (rst)
      matrix_rd && !state_reg.control.read_select);

   cov_direct: cover property (@(posedge clk) disable iff (rst)
      matrix_rd && state_reg.control.read_select);

   cov_reverse: cover property (@(posedge clk) disable iff (rst)
      matrix_wr && state_reg.control.reverse_select);

   cov_ctl_write: cover property (@(posedge clk) disable iff (rst)
      control_wr && req.byteenable[0]);

   cov_unmapped: cover property (@(posedge clk) disable iff (rst)
      unmapped_rd);
endmodule
`default_nettype wire

// >>> sim/bit_matrix_transpose_unit_tb.sv
`timescale 1ns/1ns
`default_nettype none
module bit_matrix_transpose_unit_tb
   import xy_pkg::*;
;
   logic              clk;
   logic              rst;
   logic [ADDR_W-1:0] avs_address;
   logic              avs_read;
   logic              avs_write;
   logic [3:0]        avs_byteenable;
   logic [31:0]       avs_writedata;
   logic [31:0]       avs_readdata;
   logic              avs_waitrequest;
   int                errors;
   int                check_count;
   word_t             rows [WORDS];
   logic [31:0]       q;

   // One bus access: write flag, address, write data, expected read data
   typedef struct packed {
      logic              w;
      logic [ADDR_W-1:0] a;
      logic [31:0]       d;
      logic [31:0]       x;
   } step_t;

   step_t             steps [64];
   int                nsteps;

   bit_matrix_transpose_unit u_dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic close_out();
      $display("errors=%0d checks=%0d", errors, check_count);
      if (errors == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Entered just after a rising edge; leaves one idle edge so releases never clash with the next request
   task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      avs_address   <= a;
      avs_write     <= w;
      avs_read      <= !w;
      avs_writedata <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) errors++;
      r = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask

   task automatic chk(input logic [31:0] x, input logic [31:0] g);
      check_count++;
      if (g !== x) begin
         errors++;
         $display("[FAIL] %0t exp %h got %h", $time, x, g);
      end
   endtask

   task automatic chk_bit(input logic x, input logic g);
      check_count++;
      if (g !== x) begin
         errors++;
         $display("[FAIL] %0t exp %h got %h", $time, x, g);
      end
   endtask

   task automatic add(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [31:0] x);
      steps[nsteps] = '{w: w, a: a, d: d, x: x};
      nsteps++;
   endtask

   // Expected column j of the stored matrix
   function automatic word_t column(input int j);
      word_t c;
      for (int k = 0; k < WORDS; k++) c[k] = rows[k][j];
      return c;
   endfunction

   initial begin
      rst = 1'b1;
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_byteenable = 4'hF;
      avs_writedata = 32'h0;
      errors = 0;
      check_count = 0;
      nsteps = 0;
      for (int i = 0; i < WORDS; i++) rows[i] = 16'hA5C3 ^ word_t'(i * 16'h0F11);
      for (int i = 0; i < WORDS; i++) add(1'b1, ADDR_W'(4 * i), {16'h0, rows[i]}, 32'h0);
      for (int j = 0; j < WORDS; j++) add(1'b0, ADDR_W'(4 * j), 32'h0, {16'h0, column(j)});
      add(1'b1, CONTROL_ADDR, 32'h1, 32'h0);
      for (int j = 0; j < WORDS; j++) add(1'b0, ADDR_W'(4 * j), 32'h0, {16'h0, rows[j]});
      add(1'b1, CONTROL_ADDR, 32'h3, 32'h0);
      add(1'b1, 7'h0C, 32'h0001, 32'h0);
      rows[3] = 16'h8000;
      add(1'b0, 7'h0C, 32'h0, 32'h0000_8000);
      add(1'b1, CONTROL_ADDR, 32'h0, 32'h0);
      add(1'b0, 7'h3C, 32'h0, {16'h0, column(15)});
      add(1'b0, 7'h7C, 32'h0, UNMAPPED_DATA);
      repeat (6) @(posedge clk);
      chk_bit(1'b1, avs_waitrequest);
      rst <= 1'b0;
      @(posedge clk);
      for (int s = 0; s < nsteps; s++) begin
         bus(steps[s].w, steps[s].a, steps[s].d, q);
         if (!steps[s].w) chk(steps[s].x, q);
      end
      // Control write without lane 0 must be dropped
      avs_byteenable <= 4'hE;
      bus(1'b1, CONTROL_ADDR, 32'h3, q);
      avs_byteenable <= 4'hF;
      bus(1'b0, CONTROL_ADDR, 32'h0, q);
      chk(32'h0, q);
      bus(1'b1, CONTROL_ADDR, 32'h2, q);
      bus(1'b0, CONTROL_ADDR, 32'h0, q);
      chk(32'h2, q);
      // Mid-run reset must clear reverse_select again
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      chk_bit(1'b1, avs_waitrequest);
      rst <= 1'b0;
      @(posedge clk);
      bus(1'b0, CONTROL_ADDR, 32'h0, q);
      chk(32'h0, q);
      close_out();
   end

   // Whole run needs well under 300 bus cycles
   initial begin
      #200000;
      errors++;
      close_out();
   end
endmodule
`default_nettype wire
